// *** hdl/dqrc_ctrl.sv ***
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/100ps
// How it works
// R1: Device obeys mode writes only with low qualifier
// R2: Addressing mode enabled by setting control bit four
// R3: Clearing bit four, qualifier low, leaves addressing mode
// R4: Exit write carries the whole control register
// R5: Qualifier strobed like writes; no dynamic termination
// R6: Nominal termination follows pin with direct latencies
// R7: Reference undefined until programmed; program before use
// R8: Bit seven enables calibration; bit six range
// R9: Codes step from base; above 50 reserved
// R10: Range and level writable while calibration off
// R11: Entry write sets enable and range, level ignored
// R12: Wait entry delay before calibration commands
// R13: Only listed commands allowed in calibration mode
// R14: Dummy writes accepted before first level change
// R15: Level writes keep enable and entry range
// R16: Enable cleared in calibration exits, keeps stored
// R17: Wait settling time after each level write
// R18: Both modes together: only reference mode writes; the code also accepts the addressing exit write (OP_SDA_OFF) then
// R19: Last written range and level apply after exit
// R20: Exit only when idle, then deselects only
// R21: Final level write precedes the exit write
// R22: Range chosen only in the entry write
// R23: Calibration flag gates commands and register writes
module dqrc_ctrl
    import dqrc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Link to the device
    dqrc_link_if.ctrl        lnk
);
    typedef enum {ST_IDLE, ST_QUAL, ST_WAIT} dqrc_state_t;

    dqrc_state_t state_q;          // Sequencer state
    logic [7:0]  wait_q;           // Wait countdown
    dqrc_cmd_t   cmd_q;            // Link command
    logic [2:0]  mrIdx_q;          // Link mode register number
    logic [10:0] mrData_q;         // Link mode register contents
    logic        strobe_q;         // Qualifier strobe
    logic        qual_q;           // Qualifier level
    logic        term_q;           // Termination pin
    logic        qualPend_q;       // Qualifier to drive next
    logic [7:0]  waitLoad_q;       // Wait after the current command
    logic        cal_q;            // Device in calibration mode
    logic        sda_q;            // Device in addressing mode
    logic        bankOpen_q;       // A row is open
    logic        refProg_q;        // Reference has been programmed
    logic        range_q;          // Range chosen at entry
    logic [5:0]  code_q;           // Last level written
    logic        err_q;            // Refused order, sticky
    logic [10:0] adrImg_q;         // Addressing control image
    logic [10:0] trmImg_q;         // Termination image
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        wrAcc;            // Write access phase
    logic        cmdWr;            // Order written
    logic [3:0]  op;
    logic        legal;

    // Legal orders for the present mode
    function automatic logic opLegal(input logic [3:0] o, input logic cal, input logic sda,
                                     input logic open, input logic prog);
        logic isMrs;
        isMrs = (o == OP_ENTER) || (o == OP_SET) || (o == OP_EXIT) || (o == OP_SDA_ON)
             || (o == OP_SDA_OFF) || (o == OP_TRM);
        case (o)
            OP_ENTER:   opLegal = !cal;
            OP_SET:     opLegal = cal; // R15
            OP_EXIT:    opLegal = cal && !open; // R20
            OP_SDA_ON:  opLegal = !sda;
            OP_SDA_OFF: opLegal = sda;
            OP_TRM:     opLegal = !cal; // R13
            OP_ACT:     opLegal = !open && (cal || prog); // R7
            OP_WR:      opLegal = open;
            OP_RD:      opLegal = open;
            OP_PRE:     opLegal = 1'b1;
            default:    opLegal = 1'b0;
        endcase
        if (sda && !isMrs) begin
            opLegal = 1'b0; // R18
        end
    endfunction

    assign wrAcc = psel && penable && pwrite;
    assign cmdWr = wrAcc && paddr == OFS_CMD;
    assign op    = pwdata[3:0];
    assign legal = opLegal(op, cal_q, sda_q, bankOpen_q, refProg_q);

    // APB answer, zero wait states, data set up in the setup phase
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= 1'b1;
            if (psel && !penable) begin
                pslverr_q <= !(paddr == OFS_CMD || paddr == OFS_STATUS || paddr == OFS_MR3IMG
                               || paddr == OFS_MR1IMG);
                case (paddr)
                    OFS_STATUS: prdata_q <= {21'h000000, err_q, code_q, range_q, sda_q, cal_q,
                                             state_q != ST_IDLE};
                    OFS_MR3IMG: prdata_q <= {21'h000000, adrImg_q};
                    OFS_MR1IMG: prdata_q <= {21'h000000, trmImg_q};
                    default:    prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Mode images written by software
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            adrImg_q <= MR3IMG_RST;
            trmImg_q <= MR1IMG_RST;
        end else if (wrAcc && paddr == OFS_MR3IMG) begin
            adrImg_q <= pwdata[10:0];
        end else if (wrAcc && paddr == OFS_MR1IMG) begin
            trmImg_q <= pwdata[10:0];
        end
    end

    // Refused orders; a new refusal wins over the clear
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            err_q <= 1'b0;
        end else if (cmdWr && (state_q != ST_IDLE || !legal)) begin
            err_q <= 1'b1;
        end else if (wrAcc && paddr == OFS_STATUS && pwdata[STAT_ERR_BIT]) begin
            err_q <= 1'b0;
        end
    end

    // Sequencer: issue, strobe qualifier, wait out the delay
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q    <= ST_IDLE;
            wait_q     <= 8'h00;
            cmd_q      <= CMD_DES;
            mrIdx_q    <= 3'h0;
            mrData_q   <= 11'h000;
            strobe_q   <= 1'b0;
            qual_q     <= 1'b0;
            term_q     <= 1'b0;
            qualPend_q <= 1'b0;
            waitLoad_q <= 8'h00;
            cal_q      <= 1'b0;
            sda_q      <= 1'b0;
            bankOpen_q <= 1'b0;
            refProg_q  <= 1'b0;
            range_q    <= 1'b0;
            code_q     <= 6'h00;
        end else begin
            cmd_q    <= CMD_DES; // R20
            strobe_q <= 1'b0;
            term_q   <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cmdWr && legal) begin
                        qualPend_q <= sda_q || op == OP_SDA_OFF;
                        qual_q     <= (op == OP_SDA_OFF) ? 1'b0 : pwdata[CMD_QUAL]; // R3
                        waitLoad_q <= sda_q ? 8'(SDA_MRS_CYC) : 8'h01;
                        state_q    <= (sda_q || op == OP_SDA_OFF) ? ST_QUAL : ST_WAIT;
                        wait_q     <= 8'h01;
                        cmd_q      <= CMD_MRS;
                        case (op)
                            OP_ENTER: begin
                                mrIdx_q    <= MR_REF;
                                mrData_q   <= {3'h0, 1'b1, pwdata[CMD_RANGE], 6'h00}; // R11
                                range_q    <= pwdata[CMD_RANGE]; // R22
                                cal_q      <= !sda_q || !pwdata[CMD_QUAL]; // R1
                                waitLoad_q <= 8'(ENTRY_CYC); // R12
                            end
                            OP_SET: begin
                                mrIdx_q    <= MR_REF;
                                mrData_q   <= {3'h0, 1'b1, range_q, pwdata[CMD_CODE_LO+5:CMD_CODE_LO]}; // R15
                                code_q     <= pwdata[CMD_CODE_LO+5:CMD_CODE_LO];
                                waitLoad_q <= 8'(SETTLE_LONG_CYC); // R17
                            end
                            OP_EXIT: begin
                                mrIdx_q    <= MR_REF;
                                mrData_q   <= {3'h0, 1'b0, range_q, code_q}; // R21 R22
                                cal_q      <= sda_q && pwdata[CMD_QUAL];
                                refProg_q  <= 1'b1; // R7
                                waitLoad_q <= 8'(EXIT_CYC); // R20
                            end
                            OP_SDA_ON: begin
                                mrIdx_q  <= MR_ADDR;
                                mrData_q <= adrImg_q | (11'h001 << ADDR_MODE_BIT); // R2
                                sda_q    <= 1'b1;
                            end
                            OP_SDA_OFF: begin
                                mrIdx_q  <= MR_ADDR;
                                mrData_q <= adrImg_q & ~(11'h001 << ADDR_MODE_BIT); // R3 R4
                                sda_q    <= 1'b0;
                            end
                            OP_TRM: begin
                                mrIdx_q  <= MR_TERM;
                                mrData_q <= trmImg_q;
                            end
                            OP_ACT: begin
                                cmd_q      <= CMD_ACT; // R13
                                bankOpen_q <= 1'b1;
                            end
                            OP_WR: begin
                                cmd_q <= CMD_WR;
                            end
                            OP_RD: begin
                                cmd_q <= CMD_RD;
                            end
                            default: begin
                                cmd_q      <= CMD_PRE;
                                bankOpen_q <= 1'b0;
                            end
                        endcase
                    end
                end
                ST_QUAL: begin
                    // Qualifier strobed one cycle after the mode write
                    strobe_q <= qualPend_q; // R1
                    term_q   <= |trmImg_q[NOM_TERM_HI:NOM_TERM_LO]; // R6
                    wait_q   <= waitLoad_q;
                    state_q  <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (wait_q <= 8'h01) begin
                        state_q <= ST_IDLE;
                        if (waitLoad_q != 8'h00 && wait_q == 8'h01 && !qualPend_q) begin
                            wait_q     <= waitLoad_q;
                            waitLoad_q <= 8'h00;
                            state_q    <= ST_WAIT;
                        end
                    end else begin
                        wait_q <= wait_q - 8'h01;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign lnk.cmd          = cmd_q;
    assign lnk.mrIdx        = mrIdx_q;
    assign lnk.mrData       = mrData_q;
    assign lnk.qualStrobe   = strobe_q;
    assign lnk.laneZeroQual = qual_q;
    assign lnk.termCtl      = term_q;
endmodule

// *** hdl/dqrc_pkg.sv ***
package dqrc_pkg;
    // Clock period of sys_clk
    localparam int CLK_PERIOD_NS = 40;
    // Least waits in ns; plain defaults, round up to cycles
    localparam int ENTRY_DELAY_NS  = 150;
    localparam int EXIT_DELAY_NS   = 150;
    localparam int SETTLE_SHORT_NS = 80;
    localparam int SETTLE_LONG_NS  = 250;
    localparam int ENTRY_CYC        = (ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int EXIT_CYC         = (EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_SHORT_CYC = (SETTLE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_LONG_CYC  = (SETTLE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Mode register write spacing while single-device addressing is on
    localparam int SDA_MRS_CYC      = 10;
    // Code step beyond which the long settling time applies
    localparam logic [5:0] LONG_STEP = 6'h04;
    // Direct termination latencies in cycles
    localparam int TERM_ON_LAT  = 3;
    localparam int TERM_OFF_LAT = 2;
    localparam int TERM_DEPTH   = 4;
    // Mode register numbers
    localparam logic [2:0] MR_TERM = 3'h1;
    localparam logic [2:0] MR_ADDR = 3'h3;
    localparam logic [2:0] MR_REF  = 3'h6;
    // Field positions
    localparam int ADDR_MODE_BIT = 4;
    localparam int REF_EN_BIT    = 7;
    localparam int REF_RANGE_BIT = 6;
    localparam int NOM_TERM_LO   = 8;
    localparam int NOM_TERM_HI   = 10;
    // Highest defined level code
    localparam logic [5:0] CODE_MAX = 6'h32;
    // Link command set
    typedef enum logic [2:0] {CMD_DES, CMD_ACT, CMD_WR, CMD_WRA, CMD_RD, CMD_RDA, CMD_PRE, CMD_MRS} dqrc_cmd_t;
    // Controller register offsets
    localparam logic [7:0] OFS_CMD    = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MR3IMG = 8'h08;
    localparam logic [7:0] OFS_MR1IMG = 8'h0c;
    // Command register fields
    localparam int CMD_CODE_LO  = 8;
    localparam int CMD_RANGE    = 16;
    localparam int CMD_QUAL     = 20;
    localparam int STAT_ERR_BIT = 10;
    // Command register operations
    localparam logic [3:0] OP_ENTER   = 4'h1;
    localparam logic [3:0] OP_SET     = 4'h2;
    localparam logic [3:0] OP_EXIT    = 4'h3;
    localparam logic [3:0] OP_SDA_ON  = 4'h4;
    localparam logic [3:0] OP_SDA_OFF = 4'h5;
    localparam logic [3:0] OP_ACT     = 4'h6;
    localparam logic [3:0] OP_WR      = 4'h7;
    localparam logic [3:0] OP_RD      = 4'h8;
    localparam logic [3:0] OP_PRE     = 4'h9;
    localparam logic [3:0] OP_TRM     = 4'ha;
    // Reset values of the image registers
    localparam logic [10:0] MR3IMG_RST = 11'h000;
    localparam logic [10:0] MR1IMG_RST = 11'h000;
endpackage

// *** hdl/dqrc_link_if.sv ***
`timescale 1ns/100ps
interface dqrc_link_if;
    import dqrc_pkg::*;
    dqrc_cmd_t   cmd;          // Command, DES when idle
    logic [2:0]  mrIdx;        // Mode register number
    logic [10:0] mrData;       // Mode register contents
    logic        qualStrobe;   // Qualifier strobe, cycle after a mode write
    logic        laneZeroQual; // Lane-zero qualifier, low selects
    logic        termCtl;      // Termination control pin
    modport ctrl (output cmd, mrIdx, mrData, qualStrobe, laneZeroQual, termCtl);
    modport dev  (input cmd, mrIdx, mrData, qualStrobe, laneZeroQual, termCtl);
endinterface

// *** hdl/dqrc_device.sv ***
`timescale 1ns/100ps
module dqrc_device
    import dqrc_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    // Link from the controller
    dqrc_link_if.dev        lnk,
    // Reference and mode status
    output logic [5:0]      refCode,
    output logic            refRange,
    output logic            refValid,
    output logic            refReserved,
    output logic            calMode,
    output logic            sdaMode,
    output logic            termActive,
    output logic            writeAck,
    output logic            cmdDropped
);
    logic [5:0]            code_q;       // Stored level code
    logic                  range_q;      // Stored range
    logic [5:0]            opCode_q;     // Operating level
    logic                  opRange_q;    // Operating range
    logic                  cal_q;        // Calibration mode flag
    logic                  sda_q;        // Single-device addressing
    logic                  nomTerm_q;    // Nominal termination enabled
    logic                  pend_q;       // Mode write waiting for qualifier
    logic [2:0]            pIdx_q;       // Held mode register number
    logic [10:0]           pData_q;      // Held mode register contents
    logic [7:0]            settle_q;     // Settling countdown
    logic [TERM_DEPTH-1:0] termPipe_q;   // Termination pin delay line
    logic                  termAct_q;    // Termination state
    logic                  ack_q;        // Write accepted pulse
    logic                  drop_q;       // Command dropped pulse
    logic                  exec;         // Mode write executes now
    logic [2:0]            eIdx;
    logic [10:0]           eData;
    logic [5:0]            step;

    // Execute now outside addressing mode, else on a low qualifier
    always_comb begin
        exec  = 1'b0;
        eIdx  = lnk.mrIdx;
        eData = lnk.mrData;
        if (!sda_q) begin
            exec = (lnk.cmd == CMD_MRS);
        end else begin
            exec  = pend_q && lnk.qualStrobe && !lnk.laneZeroQual; // R1
            eIdx  = pIdx_q;
            eData = pData_q;
        end
    end

    // Hold the mode write until its qualifier is strobed
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pend_q  <= 1'b0;
            pIdx_q  <= 3'h0;
            pData_q <= 11'h000;
        end else if (sda_q && lnk.cmd == CMD_MRS) begin
            pend_q  <= 1'b1; // R5
            pIdx_q  <= lnk.mrIdx;
            pData_q <= lnk.mrData;
        end else if (lnk.qualStrobe) begin
            pend_q  <= 1'b0;
        end
    end

    // Mode register effects
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cal_q     <= 1'b0;
            sda_q     <= 1'b0;
            nomTerm_q <= 1'b0;
            code_q    <= 6'h00;
            range_q   <= 1'b0;
            opCode_q  <= 6'h00;
            opRange_q <= 1'b0;
        end else if (exec) begin
            if (eIdx == MR_ADDR) begin
                sda_q <= eData[ADDR_MODE_BIT]; // R3
            end else if (eIdx == MR_TERM) begin
                nomTerm_q <= |eData[NOM_TERM_HI:NOM_TERM_LO]; // R6
            end else if (eIdx == MR_REF) begin
                if (!cal_q && eData[REF_EN_BIT]) begin
                    cal_q   <= 1'b1; // R11 R23
                    range_q <= eData[REF_RANGE_BIT]; // R8
                end else if (!cal_q) begin
                    range_q   <= eData[REF_RANGE_BIT]; // R10
                    code_q    <= eData[5:0];
                    opRange_q <= eData[REF_RANGE_BIT];
                    opCode_q  <= eData[5:0];
                end else if (eData[REF_EN_BIT]) begin
                    code_q <= eData[5:0]; // R23
                end else begin
                    cal_q     <= 1'b0; // R16 R23
                    opRange_q <= range_q; // R19
                    opCode_q  <= code_q;
                end
            end
        end
    end

    // Step size picks the settling time
    assign step = (eData[5:0] > code_q) ? eData[5:0] - code_q : code_q - eData[5:0];

    // Reference not valid until settled
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            settle_q <= 8'h00;
        end else if (exec && eIdx == MR_REF && eData[REF_EN_BIT] && cal_q) begin
            settle_q <= (step > LONG_STEP) ? 8'(SETTLE_LONG_CYC) : 8'(SETTLE_SHORT_CYC); // R17
        end else if (settle_q != 8'h00) begin
            settle_q <= settle_q - 8'h01;
        end
    end

    // Writes are taken in calibration mode, dummy ones too
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ack_q  <= 1'b0;
            drop_q <= 1'b0;
        end else begin
            ack_q  <= (lnk.cmd == CMD_WR || lnk.cmd == CMD_WRA) && !sda_q; // R14
            // Addressing mode takes mode writes only; calibration takes mode writes to the reference only
            drop_q <= (sda_q && lnk.cmd != CMD_MRS && lnk.cmd != CMD_DES)
                   || (cal_q && lnk.cmd == CMD_MRS && lnk.mrIdx != MR_REF); // R23
        end
    end

    // Termination follows the pin by the direct latencies; no write-driven switching
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            termPipe_q <= '0;
            termAct_q  <= 1'b0;
        end else begin
            termPipe_q <= {termPipe_q[TERM_DEPTH-2:0], lnk.termCtl};
            if (!nomTerm_q) begin
                termAct_q <= 1'b0;
            end else if (termPipe_q[TERM_ON_LAT-1]) begin
                termAct_q <= 1'b1; // R5 R6
            end else if (!termPipe_q[TERM_OFF_LAT-1]) begin
                termAct_q <= 1'b0; // R6
            end
        end
    end

    assign refCode     = opCode_q;
    assign refRange    = opRange_q;
    assign refValid    = (settle_q == 8'h00);
    assign refReserved = (code_q > CODE_MAX); // R9
    assign calMode     = cal_q;
    assign sdaMode     = sda_q;
    assign termActive  = termAct_q;
    assign writeAck    = ack_q;
    assign cmdDropped  = drop_q;
endmodule

// *** verification/dqrc_asserts.sv ***
`timescale 1ns/100ps
module dqrc_asserts
    import dqrc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Link signals
    input  dqrc_cmd_t        cmd,
    input  wire logic [2:0]  mrIdx,
    input  wire logic [10:0] mrData,
    input  wire logic        qualStrobe,
    input  wire logic        laneZeroQual,
    input  wire logic        termCtl
);
    logic calQ;   // Calibration mode as seen on the link
    logic sdaQ;   // Addressing mode as seen on the link
    logic rangeQ; // Range chosen at entry
    wire  refWr = cmd == CMD_MRS && mrIdx == MR_REF;
    // Mode write takes effect at once, or at its qualifier in addressing mode
    wire  take  = (cmd == CMD_MRS && !sdaQ) || (qualStrobe && !laneZeroQual);
    // Follow the modes; mrIdx and mrData hold until the qualifier cycle
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            calQ   <= 1'b0;
            sdaQ   <= 1'b0;
            rangeQ <= 1'b0;
        end else if (take) begin
            if (mrIdx == MR_REF && !calQ && mrData[REF_EN_BIT])
                rangeQ <= mrData[REF_RANGE_BIT];
            if (mrIdx == MR_REF)
                calQ <= mrData[REF_EN_BIT];
            if (mrIdx == MR_ADDR)
                sdaQ <= mrData[ADDR_MODE_BIT];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Quiet spans after entry, level and exit writes
    sequence desRun3; (cmd == CMD_DES)[*3]; endsequence
    sequence desRun6; (cmd == CMD_DES)[*6]; endsequence
    entry_wait_a: assert property (refWr && !calQ && mrData[REF_EN_BIT] |=> desRun3)
        else $error("command too soon after calibration entry");
    settle_wait_a: assert property (refWr && calQ && mrData[REF_EN_BIT] |=> desRun6)
        else $error("command before level settled");
    exit_des_a: assert property (refWr && calQ && !mrData[REF_EN_BIT] |=> desRun3)
        else $error("non-deselect after calibration exit");
    range_keep_a: assert property (refWr && calQ |-> mrData[REF_RANGE_BIT] == rangeQ)
        else $error("range changed inside calibration");
    sda_only_mrs_a: assert property (sdaQ |-> cmd inside {CMD_DES, CMD_MRS})
        else $error("array command in addressing mode");
    strobe_follow_a: assert property (sdaQ && cmd == CMD_MRS |=> qualStrobe)
        else $error("mode write without qualifier strobe");
    sda_exit_qual_a: assert property (qualStrobe && mrIdx == MR_ADDR && !mrData[ADDR_MODE_BIT] |-> !laneZeroQual)
        else $error("addressing exit not selected low");
    term_in_qual_a: assert property (termCtl |-> qualStrobe)
        else $error("termination pin outside qualifier cycle");
endmodule

// *** verification/dq_reference_calibration_mode_tb.sv ***
`timescale 1ns/100ps
module dq_reference_calibration_mode_tb;
    import dqrc_pkg::*;
    logic        sys_clk = 1'b0;  // Bench clock
    logic        resetn  = 1'b0;  // Held low at start
    logic        psel    = 1'b0;  // APB request
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata, rdv;     // Bus read data and last value taken
    logic        pready, pslverr, errv;
    logic [5:0]  refCode;
    logic        refRange, refValid, refReserved, calMode, sdaMode, writeAck;
    int          errors = 0, checks = 0, acks = 0, n;
    dqrc_link_if lnk_i ();
    dqrc_ctrl dqrc_ctrl_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk_i.ctrl));
    dqrc_device dqrc_device_i (.sys_clk(sys_clk), .resetn(resetn), .lnk(lnk_i.dev), .refCode(refCode),
        .refRange(refRange), .refValid(refValid), .refReserved(refReserved), .calMode(calMode),
        .sdaMode(sdaMode), .termActive(), .writeAck(writeAck), .cmdDropped());
    dqrc_asserts dqrc_asserts_i (.sys_clk(sys_clk), .resetn(resetn), .cmd(lnk_i.cmd), .mrIdx(lnk_i.mrIdx),
        .mrData(lnk_i.mrData), .qualStrobe(lnk_i.qualStrobe), .laneZeroQual(lnk_i.laneZeroQual),
        .termCtl(lnk_i.termCtl));
    // 25 MHz clock
    initial forever #20 sys_clk = ~sys_clk;
    // Count write acknowledge pulses
    always @(posedge sys_clk) if (writeAck === 1'b1) acks++;
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rdv  = prdata;
        errv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Issue a command, then poll busy; status is left in rdv
    task automatic op(input logic [3:0] o, input logic [5:0] c, input logic r, input logic q);
        int k;
        k = 0;
        apb(1'b1, OFS_CMD, {11'h000, q, 3'h0, r, 2'h0, c, 4'h0, o});
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            k++;
        end while (rdv[0] !== 1'b0 && k < 100);
    endtask
    // Verdict and end of run
    task automatic final_report;
        if (errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog, far beyond the expected run
    initial begin
        #2000000;
        errors++;
        final_report();
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rdv, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({rdv[30:0], errv}, 32'h1);
        op(OP_ACT, 6'h00, 1'b0, 1'b0);
        chk({31'h0, rdv[STAT_ERR_BIT]}, 32'h1);
        apb(1'b1, OFS_STATUS, 32'h400);
        op(OP_ENTER, 6'h2a, 1'b1, 1'b0);
        chk({27'h0, rdv[3:0], calMode}, 32'h15);
        op(OP_ACT, 6'h00, 1'b0, 1'b0);
        n = acks;
        op(OP_WR, 6'h00, 1'b0, 1'b0);
        chk(acks - n, 32'h1);
        op(OP_PRE, 6'h00, 1'b0, 1'b0);
        op(OP_SET, 6'h33, 1'b1, 1'b0);
        chk({31'h0, refReserved}, 32'h1);
        op(OP_SET, 6'h32, 1'b1, 1'b0);
        chk({30'h0, refReserved, refValid}, 32'h1);
        op(OP_EXIT, 6'h05, 1'b1, 1'b0);
        chk({24'h0, calMode, refRange, refCode}, {24'h0, 2'b01, 6'h32});
        apb(1'b1, OFS_MR1IMG, 32'h100);
        op(OP_TRM, 6'h00, 1'b0, 1'b0);
        op(OP_SDA_ON, 6'h00, 1'b0, 1'b0);
        chk({31'h0, sdaMode}, 32'h1);
        op(OP_ENTER, 6'h00, 1'b0, 1'b1);
        chk({31'h0, calMode}, 32'h0);
        op(OP_ENTER, 6'h00, 1'b0, 1'b0);
        op(OP_SET, 6'h10, 1'b0, 1'b0);
        op(OP_EXIT, 6'h00, 1'b0, 1'b0);
        chk({24'h0, calMode, refRange, refCode}, {24'h0, 2'b00, 6'h10});
        op(OP_SDA_OFF, 6'h00, 1'b0, 1'b0);
        op(OP_ACT, 6'h00, 1'b0, 1'b0);
        chk({31'h0, rdv[STAT_ERR_BIT]}, 32'h0);
        n = acks;
        op(OP_WR, 6'h00, 1'b0, 1'b0);
        chk({sdaMode, acks[30:0] - n[30:0]}, 32'h1);
        final_report();
    end
endmodule
